/* core/eisl_pkg.sv */
// Package for the two-wire serial slave port: constants and carrier types.
// Assumes a single system clock domain; the bus pins are sampled by it.
package eisl_pkg;
    localparam logic [3:0] EISL_ADDR_PREFIX = 4'hA;
    localparam int EISL_ROW_BYTES = 8;
    localparam int EISL_MEM_BYTES = 256;
    localparam logic [7:0] EISL_MEM_RESET = 8'h00;
    localparam logic [7:0] EISL_PTR_RESET = 8'h00;
    localparam int EISL_NVM_WRITE_US = 10;
    localparam int EISL_CLK_MHZ = 250;
    localparam int EISL_NVM_WRITE_CYC = EISL_NVM_WRITE_US * EISL_CLK_MHZ;
    localparam logic [3:0] EISL_ACK_BIT = 4'h8;

    // Sampled bus pins plus the three address-select straps.
    typedef struct packed {
        logic scl;
        logic sda;
        logic [2:0] sel;
    } eisl_pins_t;

    // Open-drain drive of the data line.
    typedef struct packed {
        logic sda_o;
        logic sda_oe;
    } eisl_drive_t;

    typedef enum logic [2:0] {
        EISL_IDLE,
        EISL_DEVADDR,
        EISL_MEMADDR,
        EISL_WDATA,
        EISL_RDATA,
        EISL_IGNORE
    } eisl_state_t;
endpackage

/* core/eisl_slave.sv */
// Two-wire serial slave with a 256-byte flip-flop memory and row writes.
// Assumes external pull-ups on both lines and a bus master driving the clock.
`timescale 1ns/1ps

// Contract
// - Read from counter or after dummy write
// - All bytes shift most significant first
// - First byte is address plus direction
// - Slave drives only ack and read data
// - Write: address, pointer, up to eight bytes
// - Random read uses repeated start sequence
// - Multi-byte read acks all but last
// - Address is fixed prefix plus pins
// - Data line only pulled low or released
// - Mismatched address ignored until next start
// - Write pointer wraps within eight-byte row
// - No address ack during row programming
// - Read uses counter, which then advances
module eisl_slave (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_level,
    output logic sda_oe,
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0,
    output logic busy
);
    import eisl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers; only the second stage feeds logic.
    logic [4:0] sync1;
    logic [4:0] sync2;
    eisl_pins_t pin;
    eisl_pins_t pin_d;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1 <= 5'h1F;
            sync2 <= 5'h1F;
            pin_d <= '1;
        end else begin
            sync1 <= {scl_pin, sda_pin, addr_select_bit2, addr_select_bit1,
                      addr_select_bit0};
            sync2 <= sync1;
            pin_d <= pin;
        end
    end
    assign pin = eisl_pins_t'(sync2);

    // Line conditions seen in the system clock domain.
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = pin.scl && !pin_d.scl;
    assign scl_fall = !pin.scl && pin_d.scl;
    assign start_c = pin.scl && pin_d.scl && pin_d.sda && !pin.sda;
    assign stop_c = pin.scl && pin_d.scl && !pin_d.sda && pin.sda;

    // Matches the address byte against prefix and strap pins.
    function automatic logic addr_hit(input logic [7:0] b,
                                      input logic [2:0] s);
        addr_hit = (b[7:1] == {EISL_ADDR_PREFIX, s});
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Protocol state, memory and pointer.
    eisl_state_t state, next_state;
    logic [3:0] bitc, next_bitc;
    logic [7:0] shreg, next_shreg;
    logic [7:0] ptr, next_ptr;
    logic [7:0] mem [EISL_MEM_BYTES];
    logic [7:0] next_mem [EISL_MEM_BYTES];
    logic ack, next_ack;
    logic drv, next_drv;
    logic dirty, next_dirty;
    logic fresh, next_fresh;
    logic [15:0] tmr, next_tmr;
    logic tx_bit;

    assign tx_bit = shreg[7];

    // Decodes conditions and clock edges into the next protocol state.
    always_comb begin
        next_state = state;
        next_bitc = bitc;
        next_shreg = shreg;
        next_ptr = ptr;
        next_mem = mem;
        next_ack = ack;
        next_drv = drv;
        next_dirty = dirty;
        next_fresh = fresh;
        next_tmr = (tmr != 16'h0000) ? tmr - 16'h0001 : 16'h0000;
        if (start_c) begin
            // A start anywhere aborts and expects an address.
            next_state = EISL_DEVADDR;
            next_bitc = 4'h0;
            next_drv = 1'b0;
            next_ack = 1'b0;
            next_fresh = 1'b1;
        end else if (stop_c) begin
            next_state = EISL_IDLE;
            next_drv = 1'b0;
            if (dirty) begin
                // Programming time begins only after stop.
                next_tmr = 16'(EISL_NVM_WRITE_CYC);
                next_dirty = 1'b0;
            end
        end else if (state != EISL_IDLE && state != EISL_IGNORE) begin
            if (scl_rise) begin
                if (bitc < EISL_ACK_BIT) begin
                    if (state != EISL_RDATA)
                        next_shreg = {shreg[6:0], pin.sda};
                end else if (state == EISL_RDATA) begin
                    // Master ack asks for another byte.
                    next_ack = !pin.sda;
                end
            end else if (scl_fall && fresh) begin
                // The fall that closes a start is not a data bit.
                next_fresh = 1'b0;
            end else if (scl_fall) begin
                if (bitc < 4'h7) begin
                    next_bitc = bitc + 4'h1;
                    if (state == EISL_RDATA)
                        next_shreg = {shreg[6:0], 1'b0};
                end else if (bitc == 4'h7) begin
                    next_bitc = EISL_ACK_BIT;
                    next_drv = 1'b0;
                    case (state)
                        EISL_DEVADDR: begin
                            if (addr_hit(shreg, pin.sel) && !busy) begin
                                next_drv = 1'b1;
                                next_ack = 1'b1;
                            end else begin
                                next_state = EISL_IGNORE;
                            end
                        end
                        EISL_MEMADDR: begin
                            next_ptr = shreg;
                            next_drv = 1'b1;
                        end
                        EISL_WDATA: begin
                            next_mem[ptr] = shreg;
                            next_ptr = {ptr[7:3], ptr[2:0] + 3'h1};
                            next_dirty = 1'b1;
                            next_drv = 1'b1;
                        end
                        EISL_RDATA: next_drv = 1'b0;
                        default: next_state = EISL_IGNORE;
                    endcase
                end else begin
                    // End of the ninth bit: choose what follows.
                    next_bitc = 4'h0;
                    next_drv = 1'b0;
                    case (state)
                        EISL_DEVADDR: begin
                            if (shreg[0]) begin
                                next_state = EISL_RDATA;
                                next_shreg = mem[ptr];
                                next_ptr = ptr + 8'h01;
                                next_drv = !mem[ptr][7];
                            end else begin
                                next_state = EISL_MEMADDR;
                            end
                        end
                        EISL_MEMADDR: next_state = EISL_WDATA;
                        EISL_WDATA: next_state = EISL_WDATA;
                        EISL_RDATA: begin
                            if (ack) begin
                                next_shreg = mem[ptr];
                                next_ptr = ptr + 8'h01;
                                next_drv = !mem[ptr][7];
                            end else begin
                                next_state = EISL_IGNORE;
                            end
                        end
                        default: next_state = EISL_IGNORE;
                    endcase
                end
                // Read data bits change only after a falling edge.
                if (state == EISL_RDATA && bitc < 4'h7)
                    next_drv = !shreg[6];
            end
        end
    end

    // Registers of the protocol engine.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= EISL_IDLE;
            bitc <= 4'h0;
            shreg <= 8'h00;
            ptr <= EISL_PTR_RESET;
            ack <= 1'b0;
            drv <= 1'b0;
            dirty <= 1'b0;
            fresh <= 1'b0;
            tmr <= 16'h0000;
        end else begin
            state <= next_state;
            bitc <= next_bitc;
            shreg <= next_shreg;
            ptr <= next_ptr;
            ack <= next_ack;
            drv <= next_drv;
            dirty <= next_dirty;
            fresh <= next_fresh;
            tmr <= next_tmr;
        end
    end

    // Memory array, one register per byte.
    genvar gi;
    generate
        for (gi = 0; gi < EISL_MEM_BYTES; gi++) begin : g_mem
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn)
                    mem[gi] <= EISL_MEM_RESET;
                else
                    mem[gi] <= next_mem[gi];
            end
        end
    endgenerate

    // Open-drain drive: the value is always low and only the enable moves,
    // so a high level can only ever come from the pull-up.
    eisl_drive_t line_drv;
    assign line_drv = '{sda_o: 1'b0, sda_oe: drv};
    assign sda_level = line_drv.sda_o;
    assign sda_oe = line_drv.sda_oe;
    assign busy = (tmr != 16'h0000);

    ////////////////////////////////////////////////////////////////////
    // Checks.
    property p_low_only;
        @(posedge clk_sys) disable iff (!rstn) sda_oe |-> !sda_level;
    endproperty
    a_low_only: assert property (p_low_only) else $error("high");

    property p_change_low;
        @(posedge clk_sys) disable iff (!rstn)
            $changed(sda_oe) |-> !pin.scl || start_c || stop_c;
    endproperty
    a_change_low: assert property (p_change_low) else $error("moved");

    property p_stop_release;
        @(posedge clk_sys) disable iff (!rstn) stop_c |=> !sda_oe;
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("held");

    property p_start_abort;
        @(posedge clk_sys) disable iff (!rstn)
            start_c |=> state == EISL_DEVADDR && bitc == 4'h0;
    endproperty
    a_start_abort: assert property (p_start_abort)
        else $error("no abort");

    property p_ignore;
        @(posedge clk_sys) disable iff (!rstn)
            state == EISL_IGNORE && !start_c |=> !sda_oe;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored drive");

    property p_busy_nak;
        @(posedge clk_sys) disable iff (!rstn)
            state == EISL_DEVADDR && busy && scl_fall && bitc == 4'h7
            |=> !sda_oe;
    endproperty
    a_busy_nak: assert property (p_busy_nak) else $error("busy ack");

    property p_row_wrap;
        @(posedge clk_sys) disable iff (!rstn)
            state == EISL_WDATA && scl_fall && bitc == 4'h7 && !start_c
            && !stop_c |=> ptr[7:3] == $past(ptr[7:3]);
    endproperty
    a_row_wrap: assert property (p_row_wrap) else $error("row left");

    property p_ptr_load;
        @(posedge clk_sys) disable iff (!rstn)
            state == EISL_MEMADDR && scl_fall && bitc == 4'h7 && !start_c
            && !stop_c |=> ptr == $past(shreg);
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("ptr load");
endmodule

/* sim/eisl_master.sv */
// Bus master model: makes the serial clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up and feeds it back.
`timescale 1ns/1ps
module eisl_master (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // The clock starts driven high and the data line released, so the pull-up holds it high.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // A quarter of the 160 ns bus period is ten system cycles.
    task automatic q();
        repeat (10) @(posedge clk_sys);
    endtask

    // Data moves only while the clock is low; a 1 is sent by releasing.
    task automatic bit_io(input logic d, output logic b);
        sda_pull <= ~d;
        q();
        scl <= 1'b1;
        q();
        b = sda_line;
        q();
        scl <= 1'b0;
        q();
    endtask

    // Also serves as a repeated start: data is released before clock rises.
    task automatic start();
        sda_pull <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask

    // The clock is left high afterwards, which marks the bus as free.
    task automatic stop();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask

    // Eight bits then the ninth; on reads the ninth is the master's answer.
    task automatic byte_io(input logic [7:0] d, input logic ninth,
                           output logic [7:0] r, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ninth, b);
        ack = ~b;
    endtask
endmodule

/* sim/eeprom_style_i2c_slave_tb.sv */
// Self-checking bench for the two-wire slave driven by a master model.
// Assumes the package, the slave and the master model are compiled first.
`timescale 1ns/1ps
module eeprom_style_i2c_slave_tb;
    import eisl_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] sel = 3'h5;
    logic scl, sda_pull, sda_o, sda_oe, busy, sda_line, ack, scl_q, oe_q;
    logic [7:0] r;
    int n_fail = 0;
    int checks_done = 0;

    // The line is a wired-and of both parties with a pull-up.
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));
    always #2 clk_sys = ~clk_sys;

    eisl_slave eisl_slave_inst (.clk_sys(clk_sys), .rstn(rstn),
        .scl_pin(scl), .sda_pin(sda_line), .sda_level(sda_o),
        .sda_oe(sda_oe),
        .addr_select_bit2(sel[2]), .addr_select_bit1(sel[1]),
        .addr_select_bit0(sel[0]), .busy(busy));
    eisl_master eisl_master_inst (.clk_sys(clk_sys), .sda_line(sda_line),
        .scl(scl), .sda_pull(sda_pull));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count; an unknown never passes.
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
        return {EISL_ADDR_PREFIX, s, rw};
    endfunction

    // Send one byte and judge the slave's acknowledge.
    task automatic wa(input logic [7:0] d, input logic e);
        eisl_master_inst.byte_io(d, 1'b1, r, ack);
        check("ack", {7'h00, ack}, {7'h00, e});
    endtask

    // Read one byte, answering with ack or nack, and judge the data.
    task automatic rdc(input logic nack, input logic [7:0] e);
        eisl_master_inst.byte_io(8'hFF, nack, r, ack);
        check("rdata", r, e);
    endtask

    // The drive may move only while the clock is low, and only low.
    always @(posedge clk_sys) begin
        if (rstn && scl && scl_q && sda_oe !== oe_q)
            check("oe_scl_high", {7'h00, sda_oe}, {7'h00, oe_q});
        if (sda_o !== 1'b0)
            check("drive_value", {7'h00, sda_o}, 8'h00);
        scl_q <= scl;
        oe_q <= sda_oe;
    end

    ////////////////////////////////////////////////////////////////////////
    // Three bytes from BEh wrap to B8h; then the address is refused.
    task automatic s_write();
        int i;
        eisl_master_inst.start();
        wa(dev(sel, 1'b0), 1'b1);
        wa(8'hBE, 1'b1);
        wa(8'h11, 1'b1);
        wa(8'h22, 1'b1);
        wa(8'h33, 1'b1);
        eisl_master_inst.stop();
        repeat (8) @(posedge clk_sys);
        check("busy", {7'h00, busy}, 8'h01);
        eisl_master_inst.start();
        wa(dev(sel, 1'b0), 1'b0);
        eisl_master_inst.stop();
        for (i = 0; i < EISL_NVM_WRITE_CYC && busy === 1'b1; i++)
            @(posedge clk_sys);
        if (busy !== 1'b0) begin
            n_fail++;
            complete_run();
        end
    endtask

    // Dummy-write reads, a counter read and a multi-byte read.
    task automatic s_reads();
        eisl_master_inst.start();
        wa(dev(sel, 1'b0), 1'b1);
        wa(8'hB8, 1'b1);
        eisl_master_inst.start();
        wa(dev(sel, 1'b1), 1'b1);
        rdc(1'b1, 8'h33);
        eisl_master_inst.stop();
        eisl_master_inst.start();
        wa(dev(sel, 1'b1), 1'b1);
        rdc(1'b1, 8'h00);
        eisl_master_inst.stop();
        eisl_master_inst.start();
        wa(dev(sel, 1'b0), 1'b1);
        wa(8'hBE, 1'b1);
        eisl_master_inst.start();
        wa(dev(sel, 1'b1), 1'b1);
        rdc(1'b0, 8'h11);
        rdc(1'b0, 8'h22);
        rdc(1'b1, 8'h00);
        eisl_master_inst.stop();
    endtask

    // Every strap value: a foreign address silences the slave until start.
    task automatic s_select();
        for (int s = 0; s < 8; s++) begin
            sel <= 3'(s);
            repeat (4) @(posedge clk_sys);
            eisl_master_inst.start();
            wa(dev(3'(s) ^ 3'h1, 1'b1), 1'b0);
            wa(dev(3'(s), 1'b1), 1'b0);
            eisl_master_inst.start();
            wa(dev(3'(s), 1'b1), 1'b1);
            eisl_master_inst.byte_io(8'hFF, 1'b1, r, ack);
            check("sel_rdata", r, 8'h00);
            eisl_master_inst.stop();
        end
    endtask

    // A start three bits into the pointer byte must reopen addressing.
    task automatic s_abort();
        eisl_master_inst.start();
        wa(dev(sel, 1'b0), 1'b1);
        repeat (3) eisl_master_inst.bit_io(1'b0, ack);
        eisl_master_inst.start();
        wa(dev(sel, 1'b1), 1'b1);
        eisl_master_inst.byte_io(8'hFF, 1'b1, r, ack);
        check("abort_rdata", r, 8'h00);
        eisl_master_inst.stop();
        repeat (8) @(posedge clk_sys);
        check("release", {7'h00, sda_oe}, 8'h00);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        check("oe_reset", {7'h00, sda_oe}, 8'h00);
        check("busy_reset", {7'h00, busy}, 8'h00);
        repeat (3) @(posedge clk_sys);
        s_write();
        s_reads();
        s_select();
        s_abort();
        complete_run();
    end
endmodule
